// File: common/smb_pkg.sv
// Types shared by the SMBus slave register port
package smb_pkg;

    // Byte engine states
    typedef enum logic [2:0] {
        SMB_IDLE,
        SMB_ADDR,
        SMB_ACK_ADDR,
        SMB_WR_BYTE,
        SMB_ACK_WR,
        SMB_RD_BYTE,
        SMB_RD_ACK
    } smb_state_t;

    // Measured values handed in by the core
    typedef struct packed {
        logic [7:0] ch2_val_int;
        logic [7:0] ch2_val_fr;
        logic [7:0] status2;
    } smb_sense_t;

    // Writable register contents handed out to the core
    typedef struct packed {
        logic [7:0] cfg1;
        logic [7:0] ch1_low_fr;
        logic [7:0] ch1_shut;
        logic [7:0] loc_shut;
        logic [7:0] hyst;
        logic [7:0] alert;
        logic [7:0] cfg2;
        logic [7:0] ch2_hi_int;
        logic [7:0] ch2_lo_int;
        logic [7:0] ch2_off_int;
        logic [7:0] ch2_off_fr;
        logic [7:0] ch2_hi_fr;
        logic [7:0] ch2_lo_fr;
        logic [7:0] ch2_shut;
    } smb_cfg_t;

endpackage : smb_pkg

// File: common/smb_regs.svh
// Register offsets, reset values, field positions and timing figures of the SMBus port
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH

// ****************************************************************
// Bus address and byte framing
// ****************************************************************
`define SMB_DEV_ADDR       7'h4c
`define SMB_BYTE_BITS      4'h8
`define SMB_LAST_RD_BIT    4'h7
`define SMB_WR_PTR_BYTE    2'h0
`define SMB_WR_DATA_BYTE   2'h1
`define SMB_WR_DONE        2'h2

// ****************************************************************
// Register offsets
// ****************************************************************
`define SMB_A_CFG1_RD      8'h03
`define SMB_A_CFG1_WR      8'h09
`define SMB_A_ONESHOT      8'h0f
`define SMB_A_SH_LOWFRAC   8'h14
`define SMB_A_SH_SHUT      8'h19
`define SMB_A_LOC_SHUT     8'h20
`define SMB_A_HYST         8'h21
`define SMB_A_ALERT        8'h22
`define SMB_A_STAT2        8'h23
`define SMB_A_CFG2         8'h24
`define SMB_A_CH2_VAL_INT  8'h30
`define SMB_A_CH2_HI_INT   8'h31
`define SMB_A_CH2_LO_INT   8'h32
`define SMB_A_CH2_VAL_FR   8'h33
`define SMB_A_CH2_OFF_INT  8'h34
`define SMB_A_CH2_OFF_FR   8'h35
`define SMB_A_CH2_HI_FR    8'h36
`define SMB_A_CH2_LO_FR    8'h37
`define SMB_A_CH2_SHUT     8'h39
`define SMB_A_MAKER        8'hfe
`define SMB_A_REV          8'hff

// ****************************************************************
// Reset values and fields
// ****************************************************************
`define SMB_RST_ZERO       8'h00
`define SMB_RST_LIMIT      8'h55
`define SMB_RST_HYST       8'h0a
`define SMB_RST_ALERT      8'h01
`define SMB_RST_PTR        8'h00
`define SMB_CFG1_SEL_BIT   3
`define SMB_ALERT_SCL_BIT  7
`define SMB_ALERT_SDA_BIT  6

// ****************************************************************
// Timing
// ****************************************************************
`define SMB_TMO_MS         25
`define SMB_CLK_HZ         20000000

`endif

// File: dv/smb_host_model.sv
// SMBus host controller model: clock master, open-drain data
`timescale 1ns/1ps
module smb_host_model (
    input  wire logic clk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_oe
);
    localparam int HALF = 20;  // Core cycles per phase, 1 us
    // Idle bus: clock driven high, data left to the pull-up
    initial begin
        scl    = 1'b1;
        sda_oe = 1'b0;
    end
    // One bus phase; lines move just after a core clock edge
    task automatic ph(input logic c, input logic d);
        repeat (HALF) @(posedge clk);
        scl    <= c;
        sda_oe <= ~d;
    endtask : ph
    task automatic start();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);  // Data falls, clock high
        ph(1'b0, 1'b0);
    endtask : start
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);  // Data rises, clock high
    endtask : stop
    // Nine clocks, MSB first; data moves only with clock low
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic [8:0] o;
        logic [8:0] s;
        o = {d, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, o[i]);
            ph(1'b1, o[i]);
            s[i] = sda_in;
            ph(1'b0, o[i]);
        end
        q   = s[8:1];
        ack = ~s[0];
    endtask : xfer
endmodule : smb_host_model

// File: dv/tb_smb_slave_port.sv
// Bench of the SMBus slave register port against a register model
`timescale 1ns/1ps
module tb_smb_slave_port;
    logic                clk = 1'b0;
    logic                bus_clk = 1'b0;
    logic                rst = 1'b1;
    logic                scl, h_oe, d_out, d_oe, mstart, k;
    smb_pkg::smb_sense_t sense = '0;
    smb_pkg::smb_cfg_t   cfg;
    logic [7:0]          m [256];
    logic [7:0]          p = 8'h00;
    logic [7:0]          a, q;
    int                  n_mismatch = 0;
    int                  comparisons = 0;
    int                  seed = 13;
    int                  n_ms = 0;
    int                  x_ms = 0;
    logic [15:0]         rv [8] = '{16'h1955, 16'h2055, 16'h3155, 16'h3955,
                                    16'h210a, 16'h2201, 16'hfe3c, 16'hff07};
    logic [7:0]          al [12] = '{8'h09, 8'h03, 8'h0f, 8'h14, 8'h19, 8'h22,
                                     8'h23, 8'h30, 8'h33, 8'h37, 8'h39, 8'hfe};
    wire                 sda = ~(h_oe | d_oe);  // Pull-up wins unless pulled low
    always #25 clk = ~clk;
    always #7.5 bus_clk = ~bus_clk;  // Link clock, unrelated phase
    // Count one-shot pulses
    always @(posedge clk) if (mstart === 1'b1) n_ms <= n_ms + 1;
    // Identity values are arbitrary; timeout well above the longest legal low run (~540 clk)
    smb_slave_port #(.MAKER_ID(8'h3c), .REVISION_ID(8'h07), .TIMEOUT_CYCLES(2000)) u_dut (
        .clk(clk), .rst(rst), .bus_clk(bus_clk), .scl_in(scl), .serial_data_line_in(sda),
        .serial_data_line_out(d_out), .serial_data_line_oe(d_oe), .sense_in(sense),
        .measure_start(mstart), .cfg_out(cfg));
    smb_host_model u_host (.clk(clk), .sda_in(sda), .scl(scl), .sda_oe(h_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Shared offsets follow the channel select bit
    function automatic logic [7:0] idx(input logic [7:0] x);
        if (m[8'h03][3] === 1'b1 && (x == 8'h14 || x == 8'h19)) return (x == 8'h14) ? 8'h37 : 8'h39;
        return x;
    endfunction : idx
    // Pointer byte, then an optional data byte
    task automatic wr(input logic [7:0] ad, input logic [7:0] d, input bit two);
        u_host.start();
        u_host.xfer(8'h98, q, k);
        chk({7'h00, k}, 8'h01);
        u_host.xfer(ad, q, k);
        chk({7'h00, k}, 8'h01);
        p = ad;
        if (two) begin
            u_host.xfer(d, q, k);
            chk({7'h00, k}, 8'h01);
            if (ad == 8'h09) m[8'h03] = d;
            else if (ad inside {8'h14, 8'h19, [8'h20:8'h22], 8'h24, 8'h31, 8'h32,
                                [8'h34:8'h37], 8'h39}) m[idx(ad)] = d;
            if (ad == 8'h0f) x_ms++;
        end
        u_host.stop();
    endtask : wr
    // One-byte read at the standing pointer
    task automatic rd();
        u_host.start();
        u_host.xfer(8'h99, q, k);
        chk({7'h00, k}, 8'h01);
        u_host.xfer(8'hff, q, k);
        chk(q, p == 8'h09 ? 8'h00 : m[idx(p)]);
        u_host.stop();
    endtask : rd
    task automatic end_sim();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    // Watchdog against a hung bus; a clean run needs about 3.8 ms
    initial begin
        #4800000;
        n_mismatch++;
        end_sim();
    end
    // Main sequence
    initial begin
        foreach (m[i]) m[i] = 8'h00;
        foreach (rv[i]) m[rv[i][15:8]] = rv[i][7:0];
        repeat (12) @(posedge clk);
        rst   <= 1'b0;
        sense <= 24'($random(seed));
        repeat (40) @(posedge clk);
        {m[8'h30], m[8'h33], m[8'h23]} = sense;
        chk(cfg.alert, 8'h01);
        rd();  // Harmless pointer after reset
        foreach (rv[i]) begin
            wr(rv[i][15:8], 8'h00, 1'b0);
            rd();
        end
        wr(8'h09, 8'h08, 1'b1);
        wr(8'h19, 8'h3a, 1'b1);
        wr(8'h39, 8'h00, 1'b0);
        rd();
        for (int i = 0; i < 8; i++) begin
            a = al[$unsigned($random(seed)) % 12];
            wr(a, 8'($random(seed)), 1'b1);
            wr(a, 8'h00, 1'b0);
            rd();
            rd();
        end
        u_host.start();
        u_host.xfer(8'h9a, q, k);
        chk({7'h00, k}, 8'h00);
        u_host.stop();
        wr(8'h22, 8'hc1, 1'b1);
        wr(8'h0f, 8'h00, 1'b0);
        u_host.start();
        u_host.xfer(8'h99, q, k);
        repeat (2100) @(posedge clk);
        chk({7'h00, d_oe}, 8'h00);
        u_host.stop();
        chk(n_ms[7:0], x_ms[7:0]);
        chk({7'h00, d_out}, 8'h00);
        chk(cfg.ch2_shut, m[8'h39]);
        end_sim();
    end
endmodule : tb_smb_slave_port

// File: rtl/smb_slave_port.sv
// SMBus slave register port: bus engine, pointer, register file, timeouts
// Operation
// - Offset 0x19 selects channel-1 or channel-2 shutdown limit by select bit; reset 0x55.
// - Channel-2 registers 0x30-0x39 reachable directly; 0x30 and 0x33 are read-only.
// - A write to 0x0F starts one measurement; its data byte is dropped.
// - Enabled timeouts abandon the transaction after a watched line stays low 25 ms; disabled at reset.
// - Alert register bit 7 enables clock timeout, bit 6 data timeout.
// - Answer only to 7-bit address 1001100; direction bit is the byte's LSB.
// - Data falling while clock high is a start; shift eight bits MSB first.
// - Matching address gets a low acknowledge on the ninth clock; else wait for start.
// - Direction bit 0 means host write, 1 means host read.
// - Nine clocks per byte; data rising while clock high is a stop.
// - Writes carry one or two bytes, reads one byte; no mixing of directions.
// - First byte after address of each write loads the register pointer.
// - Second write byte is stored into the register the pointer selects.
// - Configuration 1 bit 3 steers shared offsets to channel 2, resets to 0.
// - A read returns the register the pointer already selects.
`timescale 1ns/1ps
`include "smb_regs.svh"

module smb_slave_port #(
    parameter logic [7:0] MAKER_ID       = 8'h5a,  // Arbitrary value
    parameter logic [7:0] REVISION_ID    = 8'h01,  // Arbitrary value
    parameter int         TIMEOUT_CYCLES = `SMB_TMO_MS * (`SMB_CLK_HZ / 1000)
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             bus_clk,
    input  wire logic             scl_in,
    input  wire logic             serial_data_line_in,
    output logic                  serial_data_line_out,
    output logic                  serial_data_line_oe,
    input  wire smb_pkg::smb_sense_t sense_in,
    output logic                  measure_start,
    output smb_pkg::smb_cfg_t     cfg_out
);

    localparam int NREG = 14;
    localparam int TW   = 20;
    localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);

    // ****************************************************************
    // Register index map
    // ****************************************************************
    function automatic logic [4:0] wmap(input logic [7:0] a, input logic sel);
        // {hit, index} for a write; read-only offsets miss
        case (a)
            `SMB_A_CFG1_WR:     wmap = {1'b1, 4'd0};
            `SMB_A_SH_LOWFRAC:  wmap = sel ? {1'b1, 4'd12} : {1'b1, 4'd1};
            `SMB_A_SH_SHUT:     wmap = sel ? {1'b1, 4'd13} : {1'b1, 4'd2};
            `SMB_A_LOC_SHUT:    wmap = {1'b1, 4'd3};
            `SMB_A_HYST:        wmap = {1'b1, 4'd4};
            `SMB_A_ALERT:       wmap = {1'b1, 4'd5};
            `SMB_A_CFG2:        wmap = {1'b1, 4'd6};
            `SMB_A_CH2_HI_INT:  wmap = {1'b1, 4'd7};
            `SMB_A_CH2_LO_INT:  wmap = {1'b1, 4'd8};
            `SMB_A_CH2_OFF_INT: wmap = {1'b1, 4'd9};
            `SMB_A_CH2_OFF_FR:  wmap = {1'b1, 4'd10};
            `SMB_A_CH2_HI_FR:   wmap = {1'b1, 4'd11};
            `SMB_A_CH2_LO_FR:   wmap = {1'b1, 4'd12};
            `SMB_A_CH2_SHUT:    wmap = {1'b1, 4'd13};
            default:            wmap = {1'b0, 4'd0};
        endcase
    endfunction : wmap

    function automatic logic [7:0] reset_of(input int i);
        case (i)
            2, 3, 7, 13: reset_of = `SMB_RST_LIMIT;
            4:           reset_of = `SMB_RST_HYST;
            5:           reset_of = `SMB_RST_ALERT;
            default:     reset_of = `SMB_RST_ZERO;
        endcase
    endfunction : reset_of

    // ****************************************************************
    // Link domain: reset, pin and core synchronisers
    // ****************************************************************
    logic [1:0] brst_sync;
    logic [2:0] scl_sync, sda_sync;
    logic [2:0] abort_sync, snap_sync;
    logic       brst;
    logic       abort_tgl_reg, snap_tgl_reg;  // Core-side toggles, read through abort/snap_sync
    smb_pkg::smb_sense_t snap_hold_reg;

    // Two flops per input; the third stage only feeds edge detection
    always_ff @(posedge bus_clk) begin
        brst_sync  <= {brst_sync[0], rst};
        scl_sync   <= {scl_sync[1:0], scl_in};
        sda_sync   <= {sda_sync[1:0], serial_data_line_in};
        abort_sync <= {abort_sync[1:0], abort_tgl_reg};
        snap_sync  <= {snap_sync[1:0], snap_tgl_reg};
    end

    wire scl_lvl  = scl_sync[1];
    wire sda_lvl  = sda_sync[1];
    wire scl_rise = scl_sync[1] & ~scl_sync[2];
    wire scl_fall = ~scl_sync[1] & scl_sync[2];
    wire start_ev = scl_lvl & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
    wire stop_ev  = scl_lvl & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
    wire abort_ev = abort_sync[1] ^ abort_sync[2];
    wire snap_ev  = snap_sync[1] ^ snap_sync[2];
    assign brst   = brst_sync[1];

    // ****************************************************************
    // Link domain: byte engine
    // ****************************************************************
    smb_pkg::smb_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [1:0] nb_reg, nb_next;
    logic       oe_reg, oe_next;
    logic [7:0] rd_data;
    logic [7:0] regs [NREG];

    wire byte_done = (cnt_reg == `SMB_BYTE_BITS);
    wire sel       = regs[0][`SMB_CFG1_SEL_BIT];
    wire wr_en     = (state_reg == smb_pkg::SMB_WR_BYTE) & scl_fall & byte_done
                     & (nb_reg == `SMB_WR_DATA_BYTE);
    wire [4:0] wsel = wmap(ptr_reg, sel);

    // Next state; an expired timeout outranks everything, then start, then stop
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        tx_next    = tx_reg;
        ptr_next   = ptr_reg;
        nb_next    = nb_reg;
        oe_next    = oe_reg;
        if (abort_ev) begin
            state_next = smb_pkg::SMB_IDLE;
            oe_next    = 1'b0;
        end else if (start_ev) begin
            state_next = smb_pkg::SMB_ADDR;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end else if (stop_ev) begin
            state_next = smb_pkg::SMB_IDLE;
            oe_next    = 1'b0;
        end else begin
            case (state_reg)
                smb_pkg::SMB_ADDR: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_lvl};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        if (shift_reg[7:1] == `SMB_DEV_ADDR) begin
                            state_next = smb_pkg::SMB_ACK_ADDR;
                            oe_next    = 1'b1;
                        end else begin
                            state_next = smb_pkg::SMB_IDLE;
                        end
                    end
                end
                smb_pkg::SMB_ACK_ADDR: begin
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        nb_next  = `SMB_WR_PTR_BYTE;
                        if (shift_reg[0]) begin
                            state_next = smb_pkg::SMB_RD_BYTE;
                            tx_next    = rd_data;
                            oe_next    = ~rd_data[7];
                        end else begin
                            state_next = smb_pkg::SMB_WR_BYTE;
                            oe_next    = 1'b0;
                        end
                    end
                end
                smb_pkg::SMB_WR_BYTE: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_lvl};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        if (nb_reg == `SMB_WR_PTR_BYTE) begin
                            ptr_next = shift_reg;
                        end
                        if (nb_reg == `SMB_WR_DONE) begin
                            state_next = smb_pkg::SMB_IDLE;
                        end else begin
                            state_next = smb_pkg::SMB_ACK_WR;
                            oe_next    = 1'b1;
                            nb_next    = nb_reg + 2'h1;
                        end
                    end
                end
                smb_pkg::SMB_ACK_WR: begin
                    if (scl_fall) begin
                        state_next = smb_pkg::SMB_WR_BYTE;
                        cnt_next   = 4'h0;
                        oe_next    = 1'b0;
                    end
                end
                smb_pkg::SMB_RD_BYTE: begin
                    if (scl_fall) begin
                        if (cnt_reg == `SMB_LAST_RD_BIT) begin
                            state_next = smb_pkg::SMB_RD_ACK;
                            oe_next    = 1'b0;
                        end else begin
                            cnt_next = cnt_reg + 4'h1;
                            tx_next  = {tx_reg[6:0], 1'b0};
                            oe_next  = ~tx_reg[6];
                        end
                    end
                end
                smb_pkg::SMB_RD_ACK: begin
                    // One byte per read; acknowledge or not, go idle at the ninth clock's rise
                    if (scl_rise) begin
                        state_next = smb_pkg::SMB_IDLE;
                    end
                end
                default: state_next = smb_pkg::SMB_IDLE;
            endcase
        end
    end

    // Engine flops
    always_ff @(posedge bus_clk) begin
        if (brst) begin
            state_reg <= smb_pkg::SMB_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= `SMB_RST_ZERO;
            tx_reg    <= `SMB_RST_ZERO;
            ptr_reg   <= `SMB_RST_PTR;
            nb_reg    <= `SMB_WR_PTR_BYTE;
            oe_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            tx_reg    <= tx_next;
            ptr_reg   <= ptr_next;
            nb_reg    <= nb_next;
            oe_reg    <= oe_next;
        end
    end

    // Open drain: the line is only ever pulled low
    assign serial_data_line_out = 1'b0;
    assign serial_data_line_oe  = oe_reg;

    // ****************************************************************
    // Link domain: register file
    // ****************************************************************
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        always_ff @(posedge bus_clk) begin
            if (brst) begin
                regs[i] <= reset_of(i);
            end else if (wr_en && wsel[4] && (wsel[3:0] == 4'(i))) begin
                regs[i] <= shift_reg;
            end
        end
    end

    // Core values are copied only when the handshake says they are stable
    smb_pkg::smb_sense_t sense_reg;
    logic                snap_ack_reg;
    always_ff @(posedge bus_clk) begin
        if (brst) begin
            sense_reg    <= '0;
            snap_ack_reg <= 1'b0;
        end else if (snap_ev) begin
            sense_reg    <= snap_hold_reg;
            snap_ack_reg <= snap_sync[1];
        end
    end

    // Read decode; read-only offsets have no write path at all
    always_comb begin
        case (ptr_reg)
            `SMB_A_CFG1_RD:     rd_data = regs[0];
            `SMB_A_SH_LOWFRAC:  rd_data = sel ? regs[12] : regs[1];
            `SMB_A_SH_SHUT:     rd_data = sel ? regs[13] : regs[2];
            `SMB_A_LOC_SHUT:    rd_data = regs[3];
            `SMB_A_HYST:        rd_data = regs[4];
            `SMB_A_ALERT:       rd_data = regs[5];
            `SMB_A_STAT2:       rd_data = sense_reg.status2;
            `SMB_A_CFG2:        rd_data = regs[6];
            `SMB_A_CH2_VAL_INT: rd_data = sense_reg.ch2_val_int;
            `SMB_A_CH2_HI_INT:  rd_data = regs[7];
            `SMB_A_CH2_LO_INT:  rd_data = regs[8];
            `SMB_A_CH2_VAL_FR:  rd_data = sense_reg.ch2_val_fr;
            `SMB_A_CH2_OFF_INT: rd_data = regs[9];
            `SMB_A_CH2_OFF_FR:  rd_data = regs[10];
            `SMB_A_CH2_HI_FR:   rd_data = regs[11];
            `SMB_A_CH2_LO_FR:   rd_data = regs[12];
            `SMB_A_CH2_SHUT:    rd_data = regs[13];
            `SMB_A_MAKER:       rd_data = MAKER_ID;
            `SMB_A_REV:         rd_data = REVISION_ID;
            default:            rd_data = `SMB_RST_ZERO;
        endcase
    end

    assign cfg_out = {regs[0], regs[1], regs[2], regs[3], regs[4], regs[5], regs[6],
                      regs[7], regs[8], regs[9], regs[10], regs[11], regs[12], regs[13]};

    // Levels and events bound for the core clock
    logic       os_tgl_reg;
    logic [4:0] lvl_reg;
    always_ff @(posedge bus_clk) begin
        if (brst) begin
            os_tgl_reg <= 1'b0;
            lvl_reg    <= 5'h00;
        end else begin
            if (wr_en && ptr_reg == `SMB_A_ONESHOT) begin
                os_tgl_reg <= ~os_tgl_reg;
            end
            lvl_reg <= {regs[5][`SMB_ALERT_SCL_BIT], regs[5][`SMB_ALERT_SDA_BIT],
                        state_reg != smb_pkg::SMB_IDLE, ~scl_lvl, ~sda_lvl};
        end
    end

    // ****************************************************************
    // Core domain: timeout, one-shot pulse, value snapshot
    // ****************************************************************
    logic [4:0]    lvl_s1, lvl_s2;
    logic [2:0]    os_sync;
    logic [1:0]    ack_sync;
    logic [TW-1:0] tmo_cnt_reg;

    always_ff @(posedge clk) begin
        lvl_s1   <= lvl_reg;
        lvl_s2   <= lvl_s1;
        os_sync  <= {os_sync[1:0], os_tgl_reg};
        ack_sync <= {ack_sync[0], snap_ack_reg};
    end

    // Each enable gates only its own stuck line, and only inside a transaction
    wire tmo_run = lvl_s2[2] & ((lvl_s2[4] & lvl_s2[1]) | (lvl_s2[3] & lvl_s2[0]));
    wire tmo_hit = tmo_run & (tmo_cnt_reg == TMO_LAST);

    always_ff @(posedge clk) begin
        if (rst) begin
            tmo_cnt_reg   <= '0;
            abort_tgl_reg <= 1'b0;
        end else begin
            tmo_cnt_reg <= (tmo_run && !tmo_hit) ? tmo_cnt_reg + TW'(1) : '0;
            if (tmo_hit) begin
                abort_tgl_reg <= ~abort_tgl_reg;
            end
        end
    end

    // New snapshot only after the link side echoed the last one
    always_ff @(posedge clk) begin
        if (rst) begin
            snap_tgl_reg  <= 1'b0;
            snap_hold_reg <= '0;
            measure_start <= 1'b0;
        end else begin
            measure_start <= os_sync[1] ^ os_sync[2];
            if (ack_sync[1] == snap_tgl_reg) begin
                snap_hold_reg <= sense_in;
                snap_tgl_reg  <= ~snap_tgl_reg;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_addr_ack: assert property (@(posedge bus_clk) disable iff (brst)
        (state_reg == smb_pkg::SMB_ADDR && scl_fall && byte_done && !abort_ev && !start_ev
         && shift_reg[7:1] == `SMB_DEV_ADDR) |=> oe_reg && state_reg == smb_pkg::SMB_ACK_ADDR)
        else $error("matching address not acknowledged");
    chk_addr_miss: assert property (@(posedge bus_clk) disable iff (brst)
        (state_reg == smb_pkg::SMB_ADDR && scl_fall && byte_done && !abort_ev && !start_ev
         && shift_reg[7:1] != `SMB_DEV_ADDR) |=> !oe_reg && state_reg == smb_pkg::SMB_IDLE)
        else $error("foreign address acknowledged");
    chk_start_seen: assert property (@(posedge bus_clk) disable iff (brst)
        (start_ev && !abort_ev) |=> state_reg == smb_pkg::SMB_ADDR && cnt_reg == 4'h0)
        else $error("start not taken");
    chk_stop_seen: assert property (@(posedge bus_clk) disable iff (brst)
        stop_ev |=> state_reg == smb_pkg::SMB_IDLE && !oe_reg)
        else $error("stop not taken");
    chk_oe_scl_low: assert property (@(posedge bus_clk) disable iff (brst)
        $rose(oe_reg) |-> !scl_lvl)
        else $error("data line driven while clock high");
    chk_ptr_load: assert property (@(posedge bus_clk) disable iff (brst)
        (wr_en == 1'b0 && state_reg == smb_pkg::SMB_WR_BYTE && scl_fall && byte_done
         && nb_reg == `SMB_WR_PTR_BYTE && !abort_ev) |=> ptr_reg == $past(shift_reg))
        else $error("pointer not loaded by first byte");
    chk_oneshot: assert property (@(posedge bus_clk) disable iff (brst)
        (wr_en && ptr_reg == `SMB_A_ONESHOT) |=> os_tgl_reg != $past(os_tgl_reg))
        else $error("one-shot write lost");
    chk_shared_map: assert property (@(posedge bus_clk) disable iff (brst)
        (state_reg == smb_pkg::SMB_ACK_ADDR && scl_fall && shift_reg[0] && !abort_ev
         && !start_ev && !stop_ev && ptr_reg == `SMB_A_SH_SHUT)
        |=> tx_reg == ($past(sel) ? regs[13] : regs[2]))
        else $error("shared shutdown limit read from wrong channel");
    chk_abort_idle: assert property (@(posedge bus_clk) disable iff (brst)
        abort_ev |=> state_reg == smb_pkg::SMB_IDLE && !oe_reg)
        else $error("timeout did not release the bus");
    chk_tmo_gate: assert property (@(posedge clk) disable iff (rst)
        (tmo_cnt_reg != '0) |-> (lvl_s2[4] || lvl_s2[3]))
        else $error("timeout counting while disabled");

endmodule : smb_slave_port
